// ==== adc_ctrl_top.sv ====
// Control pin sequencing and output formatting of a dual high-speed converter
// ----------------------------------------------------------------
// Functional notes
// - wait-select input chooses short or long power-up wait before self-tuning.
// - full power-down at power-up holds the wait counter until released.
// - extended mode always uses the short power-up wait.
// - launch-edge high changes data on strobe rise, low on strobe fall.
// - dual-edge routes one input to both converters, other input idle.
// - pin mode with floating wait-select: dual-edge on I, short wait.
// - extended mode lets either input feed dual-edge sampling.
// - full power-down stops everything; second-channel sleep stops only Q, and only outside dual-edge mode.
// - sleeping channel outputs tri-state; receiver flushes pipeline afterwards.
// - power-down during tuning waits for tuning to finish.
// - tuning requests are ignored while powered down.
// - odd and even conversions go to two buses at half rate.
// - one output strobe serves all four buses.
// - DDR mode gives a word on each strobe edge, strobe at quarter rate.
// - output codes are offset binary.
// - tuning-active high during tuning; strobe idle meanwhile.
// - request needs 80 clocks low, 80 high; tuning starts 80 after rise.
// - request pin high at power-up skips power-on tuning.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "adc_ctrl_defs.svh"
module adc_ctrl_top #(
    parameter int SHORT_WAIT_CYCLES = 8192,
    parameter int LONG_WAIT_CYCLES  = 65536,
    parameter int TUNE_CYCLES       = 4096
) (
    input  wire logic                         clock,
    input  wire logic                         rst,
    input  wire logic                         link_clock,
    input  wire adc_ctrl_pkg::ctrl_pins_t     ctrl_pins,
    input  wire adc_ctrl_pkg::fmt_pins_t      fmt_pins,
    input  wire logic                         reg_write,
    input  wire logic [`ADDR_W-1:0]           reg_addr,
    input  wire logic [`DATA_W-1:0]           reg_wdata,
    output logic      [`DATA_W-1:0]           reg_rdata,
    input  wire logic [`SAMPLE_W-1:0]         sample_i,
    input  wire logic [`SAMPLE_W-1:0]         sample_q,
    output logic                              selftune_active,
    output logic                              powered_down,
    output logic                              drive_level_out,
    output logic                              output_strobe_p,
    output logic                              output_strobe_n,
    output adc_ctrl_pkg::lane_out_t [1:0]     lane_out
);
    import adc_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisation into the control domain
    // ----------------------------------------------------------------
    ctrl_pins_t pins;

    sync2 #(.WIDTH($bits(ctrl_pins_t))) u_ctrl_sync (
        .clock (clock),
        .din   (ctrl_pins),
        .dout  (pins)
    );

    // ----------------------------------------------------------------
    // Dual-edge control register
    // ----------------------------------------------------------------
    logic [`DATA_W-1:0] dual_edge_control_q;
    logic               reg_hit;

    assign reg_hit = (reg_addr == `REG_DUAL_EDGE_CTRL);

    // Software write path
    always_ff @(posedge clock) begin
        if (rst) begin
            dual_edge_control_q <= `DUAL_EDGE_CTRL_RST;
        end else if (reg_write && reg_hit) begin
            dual_edge_control_q <= reg_wdata;
        end
    end

    // Read data registered; unmapped offsets read zero
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= `READ_ZERO;
        end else begin
            reg_rdata <= reg_hit ? dual_edge_control_q : `READ_ZERO;
        end
    end

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    logic des_enable;
    logic des_source_q;
    logic long_wait;

    // Float pin means dual-edge only in pin mode
    assign des_enable   = pins.extended_mode ? dual_edge_control_q[`DEC_ENABLE_BIT]
                                             : pins.wait_float;
    assign des_source_q = pins.extended_mode & dual_edge_control_q[`DEC_SOURCE_Q_BIT];
    // Long wait only for a solid high pin in pin mode
    assign long_wait    = ~pins.extended_mode & ~pins.wait_float & pins.wait_select;

    // ----------------------------------------------------------------
    // Power-up strap capture of the request pin
    // ----------------------------------------------------------------
    logic started_q;
    logic skip_poweron_q;

    // Caught after release, once the sync holds a level
    always_ff @(posedge clock) begin
        if (rst) begin
            started_q      <= 1'b0;
            skip_poweron_q <= 1'b0;
        end else if (!started_q) begin
            started_q      <= 1'b1;
            skip_poweron_q <= pins.tune_request;
        end
    end

    // ----------------------------------------------------------------
    // Tuning request detector
    // ----------------------------------------------------------------
    seq_state_t             state_q;
    logic [`REQ_CNT_W-1:0]  low_cnt_q;
    logic [`REQ_CNT_W-1:0]  high_cnt_q;
    logic                   armed_q;
    logic                   tune_go;
    logic                   detect_off;

    // Noise filter: only a full low-then-high sequence counts
    assign detect_off = (state_q == ST_DOWN) || (state_q == ST_TUNE) || !started_q;
    assign tune_go    = armed_q && pins.tune_request && (high_cnt_q == `REQ_HOLD_CYCLES - 7'd1);

    // Low-phase counter saturates at the minimum
    always_ff @(posedge clock) begin
        if (rst || detect_off || pins.tune_request) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != `REQ_HOLD_CYCLES) begin
            low_cnt_q <= low_cnt_q + 7'd1;
        end
    end

    // Armed once low long enough; spent when tuning fires
    always_ff @(posedge clock) begin
        if (rst || detect_off || tune_go) begin
            armed_q <= 1'b0;
        end else if (low_cnt_q == `REQ_HOLD_CYCLES) begin
            armed_q <= 1'b1;
        end else if (!pins.tune_request && armed_q && high_cnt_q != '0) begin
            armed_q <= 1'b0;
        end
    end

    // High-phase counter; a dip low aborts
    always_ff @(posedge clock) begin
        if (rst || detect_off || !pins.tune_request || !armed_q || tune_go) begin
            high_cnt_q <= '0;
        end else begin
            high_cnt_q <= high_cnt_q + 7'd1;
        end
    end

    // ----------------------------------------------------------------
    // Power-up wait and tuning sequencer
    // ----------------------------------------------------------------
    logic [`WAIT_CNT_W-1:0] wait_cnt_q;
    logic [`TUNE_CNT_W-1:0] tune_cnt_q;
    logic [`WAIT_CNT_W-1:0] wait_target;
    logic                   wait_done;
    logic                   tune_done;

    assign wait_target = long_wait ? `WAIT_CNT_W'(LONG_WAIT_CYCLES - 1)
                                   : `WAIT_CNT_W'(SHORT_WAIT_CYCLES - 1);
    assign wait_done   = (wait_cnt_q >= wait_target);
    assign tune_done   = (tune_cnt_q == `TUNE_CNT_W'(TUNE_CYCLES - 1));

    // Wait counter frozen while full power-down is held
    always_ff @(posedge clock) begin
        if (rst) begin
            wait_cnt_q <= '0;
        end else if (state_q == ST_WAIT && !pins.full_power_down && started_q) begin
            wait_cnt_q <= wait_cnt_q + `WAIT_CNT_W'(1);
        end
    end

    // Tuning length counter
    always_ff @(posedge clock) begin
        if (rst || state_q != ST_TUNE) begin
            tune_cnt_q <= '0;
        end else begin
            tune_cnt_q <= tune_cnt_q + `TUNE_CNT_W'(1);
        end
    end

    // Main sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= ST_WAIT;
        end else begin
            case (state_q)
                ST_WAIT: begin
                    if (!pins.full_power_down && started_q && wait_done) begin
                        state_q <= skip_poweron_q ? ST_IDLE : ST_TUNE;
                    end
                end
                ST_IDLE: begin
                    if (pins.full_power_down) begin
                        state_q <= ST_DOWN;
                    end else if (tune_go) begin
                        state_q <= ST_TUNE;
                    end
                end
                ST_TUNE: begin
                    // Power-down waits for the sequence to end
                    if (tune_done) begin
                        state_q <= pins.full_power_down ? ST_DOWN : ST_IDLE;
                    end
                end
                ST_DOWN: begin
                    if (!pins.full_power_down) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_WAIT;
                end
            endcase
        end
    end

    // Status outputs, straight from flops
    always_ff @(posedge clock) begin
        if (rst) begin
            selftune_active <= 1'b0;
            powered_down    <= 1'b0;
        end else begin
            selftune_active <= (state_q == ST_TUNE);
            powered_down    <= (state_q == ST_DOWN) || (state_q == ST_WAIT && pins.full_power_down);
        end
    end

    // ----------------------------------------------------------------
    // Crossing into the link domain
    // ----------------------------------------------------------------
    // Config bits are quasi-static, trusted a few
    // link clocks later, so per-bit level syncs suffice.
    logic [6:0] to_link;
    logic [6:0] at_link;
    logic [2:0] fmt_link;
    logic       link_rst;

    assign to_link = {rst,
                      state_q == ST_TUNE,
                      state_q == ST_DOWN || state_q == ST_WAIT,
                      pins.second_sleep,
                      des_enable,
                      des_source_q,
                      1'b0};

    sync2 #(.WIDTH(7)) u_link_sync (
        .clock (link_clock),
        .din   (to_link),
        .dout  (at_link)
    );

    sync2 #(.WIDTH($bits(fmt_pins_t))) u_fmt_sync (
        .clock (link_clock),
        .din   (fmt_pins),
        .dout  (fmt_link)
    );

    logic link_tune;
    logic link_down;
    logic link_qsleep;
    logic link_des;
    logic link_src_q;
    logic launch_edge;
    logic ddr_mode;

    assign link_rst    = at_link[6];
    assign link_tune   = at_link[5];
    assign link_down   = at_link[4];
    assign link_qsleep = at_link[3];
    assign link_des    = at_link[2];
    assign link_src_q  = at_link[1];
    assign launch_edge = fmt_link[2];
    assign ddr_mode    = fmt_link[1];

    // ----------------------------------------------------------------
    // Output phase and strobe
    // ----------------------------------------------------------------
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    logic       strobe_d;

    assign phase_d = phase_q + 2'd1;

    // Bus words change each time phase steps from odd to even
    always_ff @(posedge link_clock) begin
        if (link_rst || link_tune) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_d;
        end
    end

    // SDR: one strobe period per word; DDR: one word per strobe edge
    always_comb begin
        if (ddr_mode) begin
            strobe_d = phase_d[1] ^ ~launch_edge;
        end else begin
            strobe_d = ~phase_d[0] ^ ~launch_edge;
        end
    end

    // Single strobe pair for all buses, idle during tuning
    always_ff @(posedge link_clock) begin
        if (link_rst || link_tune || link_down) begin
            output_strobe_p <= 1'b0;
            output_strobe_n <= 1'b1;
        end else begin
            output_strobe_p <= strobe_d;
            output_strobe_n <= ~strobe_d;
        end
    end

    // Drive level pin is passed to the pad drivers
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            drive_level_out <= 1'b0;
        end else begin
            drive_level_out <= fmt_link[0];
        end
    end

    // ----------------------------------------------------------------
    // Channel lanes
    // ----------------------------------------------------------------
    logic [1:0][`SAMPLE_W-1:0] lane_src;
    logic [1:0]                lane_sleep;
    logic [`SAMPLE_W-1:0]      des_src;

    // Dual-edge feeds the chosen input to both converters
    assign des_src    = link_src_q ? sample_q : sample_i;
    assign lane_src[0] = link_des ? des_src : sample_i;
    assign lane_src[1] = link_des ? des_src : sample_q;
    assign lane_sleep[0] = link_down;
    assign lane_sleep[1] = link_down | (link_qsleep & ~link_des);

    for (genvar ch = 0; ch < 2; ch++) begin : g_lane
        out_lane u_lane (
            .link_clock (link_clock),
            .link_rst   (link_rst),
            .sample     (lane_src[ch]),
            .phase_odd  (phase_q[0]),
            .sleep      (lane_sleep[ch]),
            .lane       (lane_out[ch])
        );
    end

endmodule

// ==== adc_ctrl_defs.svh ====
// Constants of the converter control block
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_W               4
`define DATA_W               16
`define REG_DUAL_EDGE_CTRL   4'hd
`define DUAL_EDGE_CTRL_RST   16'h0000
`define READ_ZERO            16'h0000

// ----------------------------------------------------------------
// Field positions of dual_edge_control
// ----------------------------------------------------------------
`define DEC_ENABLE_BIT       15
`define DEC_PHASE_AUTO_BIT   14
`define DEC_SOURCE_Q_BIT     13

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define REQ_HOLD_CYCLES      7'd80
`define REQ_CNT_W            7
`define WAIT_CNT_W           24
`define TUNE_CNT_W           16

// ----------------------------------------------------------------
// Output formatting
// ----------------------------------------------------------------
`define SAMPLE_W             8
`define SIGN_BIT             7

`endif

// ==== adc_ctrl_pkg.sv ====
// Types of the converter control block
package adc_ctrl_pkg;

    // Sequencer states of the control domain
    typedef enum logic [2:0] {
        ST_WAIT = 3'b000,
        ST_IDLE = 3'b001,
        ST_TUNE = 3'b010,
        ST_DOWN = 3'b011
    } seq_state_t;

    // Control pins as they arrive at the device
    typedef struct packed {
        logic wait_select;
        logic wait_float;
        logic extended_mode;
        logic full_power_down;
        logic second_sleep;
        logic tune_request;
    } ctrl_pins_t;

    // Format pins, consumed in the link domain
    typedef struct packed {
        logic launch_edge;
        logic ddr_mode;
        logic drive_level;
    } fmt_pins_t;

    // One channel's pair of demultiplexed buses
    typedef struct packed {
        logic       oe;
        logic [7:0] bus_a;
        logic [7:0] bus_b;
    } lane_out_t;

endpackage

// ==== sync2.sv ====
// Two-stage level synchroniser
`timescale 1ns/10ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clock) begin
        meta_q <= din;
        dout   <= meta_q;
    end

endmodule

// ==== out_lane.sv ====
// One converter channel: 1:2 demultiplex, offset binary coding and tri-state control
`timescale 1ns/10ps
`include "adc_ctrl_defs.svh"
module out_lane (
    input  wire logic                     link_clock,
    input  wire logic                     link_rst,
    input  wire logic [`SAMPLE_W-1:0]     sample,
    input  wire logic                     phase_odd,
    input  wire logic                     sleep,
    output adc_ctrl_pkg::lane_out_t       lane
);
    import adc_ctrl_pkg::*;

    logic [`SAMPLE_W-1:0] first_q;
    logic [`SAMPLE_W-1:0] coded;

    // Core delivers two's complement; flipping the sign gives offset binary
    assign coded = {~sample[`SIGN_BIT], sample[`SIGN_BIT-1:0]};

    // Hold the even word until its odd partner
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            first_q <= '0;
        end else if (!phase_odd) begin
            first_q <= coded;
        end
    end

    // Both buses change together at half rate
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            lane <= '0;
        end else begin
            lane.oe <= ~sleep;
            if (phase_odd) begin
                lane.bus_a <= first_q;
                lane.bus_b <= coded;
            end
        end
    end

endmodule

// ==== adc_ctrl_props.sv ====
// Concurrent checks on the converter control block ports
`timescale 1ns/10ps
`include "adc_ctrl_defs.svh"
module adc_ctrl_props #(
    parameter int SHORT_WAIT_CYCLES = 8192,
    parameter int TUNE_CYCLES       = 4096
) (
    input wire logic                          clock,
    input wire logic                          rst,
    input wire logic                          link_clock,
    input wire logic                          reg_write,
    input wire logic [`ADDR_W-1:0]            reg_addr,
    input wire logic [`DATA_W-1:0]            reg_wdata,
    input wire logic [`DATA_W-1:0]            reg_rdata,
    input wire logic                          selftune_active,
    input wire logic                          powered_down,
    input wire logic                          output_strobe_p,
    input wire logic                          output_strobe_n,
    input wire adc_ctrl_pkg::lane_out_t [1:0] lane_out
);
    import adc_ctrl_pkg::*;
    // ----------------------------------------------------------------
    // Helper counters and sequences
    // ----------------------------------------------------------------
    logic [15:0] run_q;
    logic [23:0] age_q;
    // Length of running tuning
    always_ff @(posedge clock) run_q <= rst ? 16'h0000 : (selftune_active ? run_q + 16'h0001 : 16'h0000);
    // Cycles since reset, saturating
    always_ff @(posedge clock) age_q <= rst ? 24'h000000 : age_q + {23'h000000, ~&age_q};
    sequence s_write_d;
        reg_write && reg_addr == `REG_DUAL_EDGE_CTRL;
    endsequence
    sequence s_read_d;
        reg_addr == `REG_DUAL_EDGE_CTRL;
    endsequence
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_write_read: assert property (@(posedge clock) disable iff (rst)
        s_write_d ##1 s_read_d |=> reg_rdata == $past(reg_wdata, 2)) else $error("read differs from write");
    a_unmapped_zero: assert property (@(posedge clock) disable iff (rst)
        reg_addr != `REG_DUAL_EDGE_CTRL |=> reg_rdata == `READ_ZERO) else $error("unmapped read not zero");
    a_tune_length: assert property (@(posedge clock) disable iff (rst)
        $fell(selftune_active) |-> run_q == TUNE_CYCLES) else $error("bad tuning length");
    a_tune_cap: assert property (@(posedge clock) disable iff (rst)
        run_q <= TUNE_CYCLES) else $error("tuning run too long");
    a_wait_first: assert property (@(posedge clock) disable iff (rst)
        $rose(selftune_active) |-> age_q >= SHORT_WAIT_CYCLES) else $error("tuned before wait");
    a_down_blocks: assert property (@(posedge clock) disable iff (rst)
        powered_down && !selftune_active |=> !selftune_active) else $error("tuned while down");
    a_tune_first: assert property (@(posedge clock) disable iff (rst)
        selftune_active |-> !powered_down) else $error("down during tuning");
    a_strobe_pair: assert property (@(posedge link_clock) disable iff (rst)
        output_strobe_n == !output_strobe_p) else $error("strobe pair broken");
    a_strobe_parked: assert property (@(posedge link_clock) disable iff (rst)
        selftune_active [*5] |-> $stable(output_strobe_p)) else $error("strobe moved in tuning");
    a_down_tristate: assert property (@(posedge link_clock) disable iff (rst)
        powered_down [*4] |-> !lane_out[0].oe && !lane_out[1].oe) else $error("lanes driven in down");
endmodule

bind adc_ctrl_top adc_ctrl_props #(
    .SHORT_WAIT_CYCLES(SHORT_WAIT_CYCLES),
    .TUNE_CYCLES(TUNE_CYCLES)
) props (.clock, .rst, .link_clock, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
    .selftune_active, .powered_down, .output_strobe_p, .output_strobe_n, .lane_out);

// ==== capture_model.sv ====
// Far side: core sample source and capture of the I buses
`timescale 1ns/10ps
module capture_model (
    input  wire logic                          link_clock,
    input  wire logic                          launch_edge,
    input  wire logic                          strobe_p,
    input  wire adc_ctrl_pkg::lane_out_t [1:0] lanes,
    output logic [7:0]                         sample_i,
    output logic [7:0]                         sample_q,
    output logic [7:0]                         cap_a,
    output logic [7:0]                         cap_b
);
    import adc_ctrl_pkg::*;
    logic strobe_prev;
    // Ramp on I so pairing is visible; Q sits at positive full scale
    initial begin
        sample_i = 8'h00;
        sample_q = 8'h7f;
        cap_a = 8'h00;
        cap_b = 8'h00;
        strobe_prev = 1'b0;
    end
    always @(posedge link_clock) sample_i <= sample_i + 8'h01;
    // Latch on the strobe edge opposite the launch edge
    always @(posedge link_clock) begin
        strobe_prev <= strobe_p;
        if (strobe_prev != strobe_p && strobe_p != launch_edge) begin
            cap_a <= lanes[0].bus_a;
            cap_b <= lanes[0].bus_b;
        end
    end
endmodule

// ==== adc_ctrl_top_test.sv ====
// Self-checking bench of the converter control block
`timescale 1ns/10ps
`include "adc_ctrl_defs.svh"
module adc_ctrl_top_test;
    import adc_ctrl_pkg::*;
    localparam int SW = 16;
    localparam int LW = 32;
    localparam int TC = 20;
    logic               clock       = 1'b0;
    logic               link_clock  = 1'b0;
    logic               rst         = 1'b1;
    ctrl_pins_t         ctrl_pins   = '0;
    fmt_pins_t          fmt_pins    = 3'b110;
    logic               reg_write   = 1'b0;
    logic [`ADDR_W-1:0] reg_addr    = 4'h0;
    logic [`DATA_W-1:0] reg_wdata   = 16'h0000;
    logic [`DATA_W-1:0] reg_rdata;
    logic [7:0]         sample_i, sample_q, cap_a, cap_b;
    logic               selftune_active, powered_down, drive_level_out, output_strobe_p, output_strobe_n;
    lane_out_t [1:0]    lane_out;
    int                 fails       = 0;
    int                 comparisons = 0;
    int                 cnt;
    // Link clock at a third of the control clock rate, rising edges aligned
    always #2 clock = ~clock;
    always #6 link_clock = ~link_clock;
    adc_ctrl_top #(.SHORT_WAIT_CYCLES(SW), .LONG_WAIT_CYCLES(LW), .TUNE_CYCLES(TC)) dut (
        .clock, .rst, .link_clock, .ctrl_pins, .fmt_pins, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
        .sample_i, .sample_q, .selftune_active, .powered_down, .drive_level_out, .output_strobe_p,
        .output_strobe_n, .lane_out);
    capture_model far (.link_clock, .launch_edge(fmt_pins.launch_edge), .strobe_p(output_strobe_p),
        .lanes(lane_out), .sample_i, .sample_q, .cap_a, .cap_b);
    // ----------------------------------------------------------------
    // Access and comparison tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic links(input int n);
        repeat (n) @(posedge link_clock);
        @(negedge clock);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        tick(2);
        #1 check("reg_rdata", reg_rdata, exp);
    endtask
    // Cycles to tuning start; 120 means none
    task automatic rise_within(input int lo, input int hi);
        cnt = 0;
        while (selftune_active !== 1'b1 && cnt < 120) begin
            @(negedge clock);
            cnt++;
        end
        check("tune start", 16'(cnt >= lo && cnt <= hi), 16'h0001);
    endtask
    task automatic tune_len;
        cnt = 0;
        while (selftune_active === 1'b1 && cnt < 200) begin
            @(negedge clock);
            cnt++;
        end
        check("tune length", 16'(cnt), 16'(TC));
    endtask
    task automatic boot(input ctrl_pins_t p, input int lo, input int hi);
        @(posedge clock);
        rst <= 1'b1;
        ctrl_pins <= p;
        tick(6);
        check("reset read", reg_rdata, `DUAL_EDGE_CTRL_RST);
        check("reset tuning", 16'(selftune_active), 16'h0000);
        rst <= 1'b0;
        rise_within(lo, hi);
    endtask
    // Host request: 85 low, then high
    task automatic request(input int lo, input int hi);
        @(posedge clock);
        ctrl_pins.tune_request <= 1'b0;
        tick(85);
        ctrl_pins.tune_request <= 1'b1;
        rise_within(lo, hi);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        boot('0, SW, SW + 10);
        tune_len();
        wr(`REG_DUAL_EDGE_CTRL, 16'h2001);
        rd(`REG_DUAL_EDGE_CTRL, 16'h2001);
        wr(4'h3, 16'hffff);
        rd(4'h3, `READ_ZERO);
        rd(`REG_DUAL_EDGE_CTRL, 16'h2001);
        for (int l = 1; l >= 0; l--) begin
            @(posedge clock);
            fmt_pins.launch_edge <= l[0];
            links(20);
            check("bus pair", cap_b, 8'(cap_a + 8'h01));
            check("offset code", lane_out[1].bus_a, 8'hff);
        end
        @(posedge clock);
        fmt_pins.drive_level <= 1'b1;
        ctrl_pins.second_sleep <= 1'b1;
        links(10);
        check("drive level", 16'(drive_level_out), 16'h0001);
        check("q sleep oe", 16'(lane_out[1].oe), 16'h0000);
        check("i awake oe", 16'(lane_out[0].oe), 16'h0001);
        @(posedge clock);
        ctrl_pins.second_sleep <= 1'b0;
        links(10);
        check("q wake oe", 16'(lane_out[1].oe), 16'h0001);
        request(80, 90);
        tune_len();
        request(80, 90);
        @(posedge clock);
        ctrl_pins.full_power_down <= 1'b1;
        tick(5);
        #1 check("down in tune", 16'(powered_down), 16'h0000);
        tick(30);
        #1 check("down after tune", 16'(powered_down), 16'h0001);
        request(120, 120);
        check("ignored request", 16'(selftune_active), 16'h0000);
        @(posedge clock);
        ctrl_pins.full_power_down <= 1'b0;
        tick(20);
        #1 check("no late tune", 16'(selftune_active), 16'h0000);
        @(posedge clock);
        ctrl_pins.wait_float <= 1'b1;
        links(20);
        check("dual edge on i", lane_out[1].bus_a, lane_out[0].bus_a);
        @(posedge clock);
        ctrl_pins.wait_float <= 1'b0;
        ctrl_pins.extended_mode <= 1'b1;
        wr(`REG_DUAL_EDGE_CTRL, 16'ha000);
        links(20);
        check("dual edge on q", lane_out[0].bus_a, 8'hff);
        wr(`REG_DUAL_EDGE_CTRL, 16'h0000);
        boot(6'b100000, LW, LW + 10);
        boot(6'b101000, SW, SW + 10);
        boot(6'b000001, 120, 120);
        boot(6'b000100, 120, 120);
        @(posedge clock);
        ctrl_pins.full_power_down <= 1'b0;
        rise_within(SW, SW + 10);
        give_verdict();
    end
    // Watchdog
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule
